// >>> hw/uem_pkg.sv
/*
 Shared constants and carriers for the endpoint interrupt gating and
 session-request VBUS timing block: register offsets, field layouts,
 reset values and the endpoint event structs.
 Assumes a 12-bit APB byte address inside the controller window.
*/
// ==========================================================
// Package
package uem_pkg;
	// Register byte offsets
	localparam logic [11:0] UEM_OFS_IN_MASK = 12'h810;
	localparam logic [11:0] UEM_OFS_OUT_MASK = 12'h814;
	localparam logic [11:0] UEM_OFS_SUMMARY = 12'h818;
	localparam logic [11:0] UEM_OFS_SUM_GATE = 12'h81C;
	localparam logic [11:0] UEM_OFS_DISCH = 12'h828;
	localparam logic [11:0] UEM_OFS_PULSE = 12'h82C;
	localparam logic [11:0] UEM_OFS_CTRL = 12'h840;
	localparam logic [11:0] UEM_OFS_IRQ_STAT = 12'h844;
	localparam logic [11:0] UEM_OFS_IRQ_EN = 12'h848;
	localparam logic [11:0] UEM_OFS_IRQ_CLR = 12'h84C;
	// Writable bits of the two event masks, reserved bits clear
	localparam logic [6:0] UEM_IN_MASK_VALID = 7'h7B;
	localparam logic [4:0] UEM_OUT_MASK_VALID = 5'h1B;
	// Reset values
	localparam logic [15:0] UEM_DISCH_RESET = 16'h17D7;
	localparam logic [11:0] UEM_PULSE_RESET = 12'h5B8;
	// Field positions
	localparam int UEM_CTRL_START = 0;
	localparam int UEM_CTRL_BUSY = 1;
	localparam int UEM_IRQ_EP = 0;
	localparam int UEM_IRQ_SRP = 1;
	localparam int UEM_EP_COUNT = 16;
	// One duration unit is 1024 PHY clocks
	localparam int UEM_UNIT_CYCLES = 1024;
	localparam int UEM_PRE_W = $clog2(UEM_UNIT_CYCLES);
	localparam logic [UEM_PRE_W-1:0] UEM_PRE_MAX = UEM_PRE_W'(UEM_UNIT_CYCLES - 1);
	// IN endpoint events, laid out as the IN mask
	typedef struct packed {
		logic nak_eff;
		logic mismatch;
		logic fifo_empty;
		logic timeout;
		logic rsvd;
		logic ep_disabled;
		logic xfer_done;
	} uem_in_ev_type;
	// OUT endpoint events, laid out as the OUT mask
	typedef struct packed {
		logic ep_off;
		logic setup_done;
		logic rsvd;
		logic ep_disabled;
		logic xfer_done;
	} uem_out_ev_type;
	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		UEM_IDLE = 3'h1,
		UEM_PULSE = 3'h2,
		UEM_DISCH = 3'h4
	} uem_srp_type;
endpackage

// >>> hw/uem_ep_gate.sv
/*
 One endpoint's sticky event flags and its gated pending bit.
 Assumes event and clear inputs are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ns
// ==========================================================
// Endpoint gate
module uem_ep_gate #(
	parameter int W = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] ev,
	input wire logic [W-1:0] clr,
	input wire logic [W-1:0] mask,
	output logic pend
);
	logic [W-1:0] flags_reg; // Sticky event flags
	logic pend_reg; // Gated summary of this endpoint

	// Set wins over clear so no event is lost
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			flags_reg <= '0;
		else
			flags_reg <= (flags_reg & ~clr) | ev;
	end

	// Pending while any unmasked flag stands
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pend_reg <= 1'b0;
		else
			pend_reg <= |(flags_reg & mask);
	end

	assign pend = pend_reg;

	// ==========================================================
	// Checks
	property p_flag_set;
		@(posedge ref_clk) disable iff (!rst_n)
		(|(ev & mask)) |=> ##1 pend_reg;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Unmasked event did not raise endpoint pending");
endmodule

// >>> hw/uem_srp_timer.sv
/*
 Session-request VBUS sequencer: a pulse phase then a discharge phase,
 each lasting its programmed count of 1024-cycle units, a zero count running one unit.
 Assumes the PHY clock is ref_clk; durations are latched at start.
*/
`timescale 1ns/1ns
// ==========================================================
// SRP timer
module uem_srp_timer (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [11:0] pulse_units,
	input wire logic [15:0] disch_units,
	output logic pulse_out,
	output logic disch_out,
	output logic busy,
	output logic done
);
	uem_pkg::uem_srp_type state_reg; // Sequencer state
	logic [uem_pkg::UEM_PRE_W-1:0] pre_reg; // Cycles within a unit
	logic [15:0] units_reg; // Units done in this phase
	logic [11:0] pulse_lat_reg; // Latched pulse length
	logic [15:0] disch_lat_reg; // Latched discharge length
	logic pulse_reg;
	logic disch_reg;
	logic done_reg;
	logic [15:0] target; // Units for the current phase
	logic phase_end; // Last cycle of a phase
	logic go; // Start accepted

	assign go = start && (state_reg == uem_pkg::UEM_IDLE);
	assign target = (state_reg == uem_pkg::UEM_PULSE) ? {4'h0, pulse_lat_reg} : disch_lat_reg;
	// Zero length still runs one unit, avoiding a zero-cycle phase
	assign phase_end = (state_reg != uem_pkg::UEM_IDLE) && (pre_reg == uem_pkg::UEM_PRE_MAX)
		&& (({1'b0, units_reg} + 17'h00001) >= {1'b0, target});

	// Phase sequencing
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= uem_pkg::UEM_IDLE;
		else
		begin
			unique case (state_reg)
				uem_pkg::UEM_IDLE:
					if (go)
						state_reg <= uem_pkg::UEM_PULSE;
				uem_pkg::UEM_PULSE:
					if (phase_end)
						state_reg <= uem_pkg::UEM_DISCH;
				uem_pkg::UEM_DISCH:
					if (phase_end)
						state_reg <= uem_pkg::UEM_IDLE;
			endcase
		end
	end

	// Unit prescaler and unit counter, restarted per phase
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= '0;
			units_reg <= 16'h0000;
		end
		else if (go || phase_end || state_reg == uem_pkg::UEM_IDLE)
		begin
			pre_reg <= '0;
			units_reg <= 16'h0000;
		end
		else
		begin
			pre_reg <= pre_reg + 1'b1;
			if (pre_reg == uem_pkg::UEM_PRE_MAX)
				units_reg <= units_reg + 16'h0001;
		end
	end

	// Durations latched so mid-run writes cannot warp a phase
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_lat_reg <= uem_pkg::UEM_PULSE_RESET;
			disch_lat_reg <= uem_pkg::UEM_DISCH_RESET;
		end
		else if (go)
		begin
			pulse_lat_reg <= pulse_units;
			disch_lat_reg <= disch_units;
		end
	end

	// Registered pin drives and completion pulse
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_reg <= 1'b0;
			disch_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			pulse_reg <= go || (pulse_reg && !phase_end);
			disch_reg <= (pulse_reg && phase_end) || (disch_reg && !phase_end);
			done_reg <= disch_reg && phase_end;
		end
	end

	assign pulse_out = pulse_reg;
	assign disch_out = disch_reg;
	assign busy = (state_reg != uem_pkg::UEM_IDLE);
	assign done = done_reg;

	// ==========================================================
	// Checks
	logic [27:0] len_reg; // Cycles spent in the current phase
	logic [27:0] pulse_exp;
	logic [27:0] disch_exp;
	logic [15:0] pulse_eff; // Pulse units, zero taken as one
	logic [15:0] disch_eff; // Discharge units, zero taken as one
	assign pulse_eff = (pulse_lat_reg == 12'h000) ? 16'h0001 : {4'h0, pulse_lat_reg};
	assign disch_eff = (disch_lat_reg == 16'h0000) ? 16'h0001 : disch_lat_reg;
	// Count starts at zero, so the last cycle reads units*1024 - 1
	assign pulse_exp = {2'h0, pulse_eff, 10'h000} - 28'h0000001;
	assign disch_exp = {2'h0, disch_eff, 10'h000} - 28'h0000001;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			len_reg <= 28'h0000000;
		else if (go || phase_end)
			len_reg <= 28'h0000000;
		else
			len_reg <= len_reg + 28'h0000001;
	end

	sequence s_pulse_to_disch;
		pulse_reg ##1 disch_reg && !pulse_reg;
	endsequence
	sequence s_disch_to_done;
		disch_reg ##1 done_reg && !disch_reg;
	endsequence

	property p_pulse_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(pulse_reg && phase_end) |-> (len_reg == pulse_exp) ##0 s_pulse_to_disch;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("VBUS pulse length differs from programmed units");

	property p_disch_len;
		@(posedge ref_clk) disable iff (!rst_n)
		(disch_reg && phase_end) |-> (len_reg == disch_exp) ##0 s_disch_to_done;
	endproperty
	a_disch_len: assert property (p_disch_len)
		else $error("VBUS discharge length differs from programmed units");

	property p_start;
		@(posedge ref_clk) disable iff (!rst_n)
		go |=> pulse_reg && !disch_reg;
	endproperty
	a_start: assert property (p_start)
		else $error("Session request did not start with a pulse");
endmodule

// >>> hw/uem_top.sv
/*
 Device endpoint interrupt gating and SRP VBUS timing, APB slave.
 Holds the IN and OUT event masks, the endpoint summary and its gate,
 the two VBUS duration registers and a small interrupt block.
 Assumes APB3 from a master on ref_clk and endpoint events as pulses.
*/
`timescale 1ns/1ns
// ==========================================================
// Top
module uem_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uem_pkg::uem_in_ev_type [15:0] in_ev,
	input wire uem_pkg::uem_in_ev_type [15:0] in_clr,
	input wire uem_pkg::uem_out_ev_type [15:0] out_ev,
	input wire uem_pkg::uem_out_ev_type [15:0] out_clr,
	output logic vbus_pulse,
	output logic vbus_discharge,
	output logic irq
);
	// ==========================================================
	// Declarations
	logic [6:0] in_mask_reg; // IN event mask
	logic [4:0] out_mask_reg; // OUT event mask
	logic [31:0] gate_reg; // Endpoint summary gate
	logic [15:0] disch_reg; // Discharge duration units
	logic [11:0] pulse_reg; // Pulse duration units
	logic [1:0] irq_stat_reg; // Sticky interrupt status
	logic [1:0] irq_en_reg; // Interrupt enables
	logic irq_reg; // Interrupt line
	logic [31:0] prdata_reg; // Read data, captured in setup
	logic pready_reg; // Access-phase answer
	logic pslverr_reg; // Unmapped address answer
	logic [15:0] in_pend; // Per IN endpoint pending
	logic [15:0] out_pend; // Per OUT endpoint pending
	logic [31:0] summary; // Pending summary word
	logic ep_irq; // Any gated endpoint pending
	logic setup; // APB setup cycle
	logic wr_en; // Write takes effect
	logic hit; // Address is mapped
	logic [31:0] rd_word; // Read mux
	logic srp_start; // Start strobe
	logic srp_busy;
	logic srp_done;
	logic vb_pulse;
	logic vb_disch;

	assign setup = psel && !penable;
	// Writes land only at the edge where pready is seen high
	assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;

	// ==========================================================
	// Endpoint gating
	genvar g;
	generate
		for (g = 0; g < uem_pkg::UEM_EP_COUNT; g = g + 1)
		begin : gen_ep
			// IN endpoint g gated by the IN mask
			uem_ep_gate #(
				.W(7)
			) u_in (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.ev(in_ev[g]),
				.clr(in_clr[g]),
				.mask(in_mask_reg),
				.pend(in_pend[g])
			);
			// OUT endpoint g gated by the OUT mask
			uem_ep_gate #(
				.W(5)
			) u_out (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.ev(out_ev[g]),
				.clr(out_clr[g]),
				.mask(out_mask_reg),
				.pend(out_pend[g])
			);
		end
	endgenerate

	// Summary halves: IN low, OUT high
	assign summary = {out_pend, in_pend};
	// Controller interrupt needs the summary bit unmasked too
	assign ep_irq = |(summary & gate_reg);

	// ==========================================================
	// SRP sequencer
	assign srp_start = wr_en && (paddr == uem_pkg::UEM_OFS_CTRL)
		&& pwdata[uem_pkg::UEM_CTRL_START];

	uem_srp_timer u_srp (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(srp_start),
		.pulse_units(pulse_reg),
		.disch_units(disch_reg),
		.pulse_out(vb_pulse),
		.disch_out(vb_disch),
		.busy(srp_busy),
		.done(srp_done)
	);

	assign vbus_pulse = vb_pulse;
	assign vbus_discharge = vb_disch;

	// ==========================================================
	// Address decode and read mux
	always_comb
	begin
		hit = 1'b1;
		rd_word = 32'h00000000;
		unique case (paddr)
			uem_pkg::UEM_OFS_IN_MASK:
				rd_word = {25'h0000000, in_mask_reg};
			uem_pkg::UEM_OFS_OUT_MASK:
				rd_word = {27'h0000000, out_mask_reg};
			uem_pkg::UEM_OFS_SUMMARY:
				rd_word = summary;
			uem_pkg::UEM_OFS_SUM_GATE:
				rd_word = gate_reg;
			uem_pkg::UEM_OFS_DISCH:
				rd_word = {16'h0000, disch_reg};
			uem_pkg::UEM_OFS_PULSE:
				rd_word = {20'h00000, pulse_reg};
			uem_pkg::UEM_OFS_CTRL:
				rd_word = {30'h00000000, srp_busy, 1'b0};
			uem_pkg::UEM_OFS_IRQ_STAT:
				rd_word = {30'h00000000, irq_stat_reg};
			uem_pkg::UEM_OFS_IRQ_EN:
				rd_word = {30'h00000000, irq_en_reg};
			// Clear register is write-only, reads zero
			uem_pkg::UEM_OFS_IRQ_CLR:
				rd_word = 32'h00000000;
			default:
				hit = 1'b0;
		endcase
	end

	// ==========================================================
	// APB answer: no wait state, answer in first access cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else if (setup)
		begin
			// Captured in setup so the answer is a flop
			pready_reg <= 1'b1;
			pslverr_reg <= !hit;
			prdata_reg <= hit ? rd_word : 32'h00000000;
		end
		else
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;

	// ==========================================================
	// Event masks, reserved bits held at zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_mask_reg <= 7'h00;
			out_mask_reg <= 5'h00;
		end
		else if (wr_en)
		begin
			if (paddr == uem_pkg::UEM_OFS_IN_MASK)
				in_mask_reg <= pwdata[6:0] & uem_pkg::UEM_IN_MASK_VALID;
			if (paddr == uem_pkg::UEM_OFS_OUT_MASK)
				out_mask_reg <= pwdata[4:0] & uem_pkg::UEM_OUT_MASK_VALID;
		end
	end

	// Summary gate, both halves writable
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			gate_reg <= 32'h00000000;
		else if (wr_en && paddr == uem_pkg::UEM_OFS_SUM_GATE)
			gate_reg <= pwdata;
	end

	// VBUS durations, read at the next session start
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			disch_reg <= uem_pkg::UEM_DISCH_RESET;
			pulse_reg <= uem_pkg::UEM_PULSE_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == uem_pkg::UEM_OFS_DISCH)
				disch_reg <= pwdata[15:0];
			if (paddr == uem_pkg::UEM_OFS_PULSE)
				pulse_reg <= pwdata[11:0];
		end
	end

	// ==========================================================
	// Interrupt block
	logic [1:0] irq_set; // Events this cycle
	logic [1:0] irq_clr; // Software clear this cycle
	assign irq_set = {srp_done, ep_irq};
	assign irq_clr = (wr_en && paddr == uem_pkg::UEM_OFS_IRQ_CLR) ? pwdata[1:0] : 2'h0;

	// Sticky status, set wins over a same-cycle clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_stat_reg <= 2'h0;
		else
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
	end

	// Enables
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_en_reg <= 2'h0;
		else if (wr_en && paddr == uem_pkg::UEM_OFS_IRQ_EN)
			irq_en_reg <= pwdata[1:0];
	end

	// Level interrupt line, one cycle behind status
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(irq_stat_reg & irq_en_reg);
	end

	assign irq = irq_reg;

	// ==========================================================
	// Checks
	sequence s_wr_in;
		wr_en && paddr == uem_pkg::UEM_OFS_IN_MASK;
	endsequence
	sequence s_wr_out;
		wr_en && paddr == uem_pkg::UEM_OFS_OUT_MASK;
	endsequence

	property p_in_mask_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		s_wr_in |=> in_mask_reg == ($past(pwdata[6:0]) & 7'h7B) && in_mask_reg[2] == 1'b0;
	endproperty
	a_in_mask_wr: assert property (p_in_mask_wr)
		else $error("IN mask did not take valid bits");

	property p_out_mask_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		s_wr_out |=> out_mask_reg == ($past(pwdata[4:0]) & 5'h1B);
	endproperty
	a_out_mask_wr: assert property (p_out_mask_wr)
		else $error("OUT mask did not take valid bits");

	property p_in_blocked;
		@(posedge ref_clk) disable iff (!rst_n)
		(in_mask_reg == 7'h00) [*2] |-> summary[15:0] == 16'h0000;
	endproperty
	a_in_blocked: assert property (p_in_blocked)
		else $error("IN summary set with all IN events masked");

	property p_out_blocked;
		@(posedge ref_clk) disable iff (!rst_n)
		(out_mask_reg == 5'h00) [*2] |-> summary[31:16] == 16'h0000;
	endproperty
	a_out_blocked: assert property (p_out_blocked)
		else $error("OUT summary set with all OUT events masked");

	property p_ep_irq;
		@(posedge ref_clk) disable iff (!rst_n)
		(|(summary & gate_reg)) && irq_en_reg[0] |=> irq_stat_reg[0]
			##1 (irq_reg || !$past(irq_en_reg[0]));
	endproperty
	a_ep_irq: assert property (p_ep_irq)
		else $error("Gated endpoint pending did not raise interrupt");

	property p_gate_block;
		@(posedge ref_clk) disable iff (!rst_n)
		(gate_reg == 32'h00000000) && !irq_stat_reg[0] && !srp_done |=> !irq_stat_reg[0];
	endproperty
	a_gate_block: assert property (p_gate_block)
		else $error("Endpoint status set with summary gate closed");

	property p_apb_answer;
		@(posedge ref_clk) disable iff (!rst_n)
		setup |=> pready_reg && (pslverr_reg == !$past(hit));
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB answer missing or wrong error flag");

	// Both gate halves take the written word
	property p_gate_wr;
		@(posedge ref_clk) disable iff (!rst_n)
		wr_en && paddr == uem_pkg::UEM_OFS_SUM_GATE |=> gate_reg == $past(pwdata);
	endproperty
	a_gate_wr: assert property (p_gate_wr)
		else $error("Summary gate did not take written word");

	// An endpoint event is never lost to a same-cycle clear
	property p_set_wins;
		@(posedge ref_clk) disable iff (!rst_n)
		irq_set[0] |=> irq_stat_reg[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("Endpoint status not set by gated pending");

	// Clear of the done bit works when no new done arrives
	property p_stat_clr;
		@(posedge ref_clk) disable iff (!rst_n)
		irq_clr[1] && !srp_done |=> !irq_stat_reg[1];
	endproperty
	a_stat_clr: assert property (p_stat_clr)
		else $error("Session done status did not clear");
endmodule

// >>> test/uem_ev_source.sv
/*
 Endpoint event source standing in for the bus side: turns one bench
 command into a one-cycle event or clear pulse on one endpoint.
 Assumes commands are held for exactly one ref_clk cycle.
*/
`timescale 1ns/1ns
// =====
// Event source
module uem_ev_source (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic fire,
	input wire logic is_out,
	input wire logic clear,
	input wire logic [3:0] ep,
	input wire logic [6:0] bits,
	output uem_pkg::uem_in_ev_type [15:0] in_ev,
	output uem_pkg::uem_in_ev_type [15:0] in_clr,
	output uem_pkg::uem_out_ev_type [15:0] out_ev,
	output uem_pkg::uem_out_ev_type [15:0] out_clr
);
	// Pulses last one cycle so a flag is set once, as a real event would be
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_ev <= '0;
			in_clr <= '0;
			out_ev <= '0;
			out_clr <= '0;
		end
		else
		begin
			in_ev <= '0;
			in_clr <= '0;
			out_ev <= '0;
			out_clr <= '0;
			// Route the command to one of four pulse groups
			if (fire)
			begin
				case ({is_out, clear})
					2'b00: in_ev[ep] <= bits;
					2'b01: in_clr[ep] <= bits;
					2'b10: out_ev[ep] <= bits[4:0];
					default: out_clr[ep] <= bits[4:0];
				endcase
			end
		end
	end
endmodule

// >>> test/usb_device_ep_irq_mask_srp_timing_bench.sv
/*
 Self-checking bench for endpoint event gating and SRP VBUS timing.
 Assumes the event source model drives all endpoint event inputs.
*/
`timescale 1ns/1ns
module usb_device_ep_irq_mask_srp_timing_bench;
	// Row: address, write data, readback, reset value
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic [31:0] r;
	} uem_row_type;
	logic ref_clk;
	logic rst_n;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	uem_pkg::uem_in_ev_type [15:0] in_ev;
	uem_pkg::uem_in_ev_type [15:0] in_clr;
	uem_pkg::uem_out_ev_type [15:0] out_ev;
	uem_pkg::uem_out_ev_type [15:0] out_clr;
	logic vbus_pulse;
	logic vbus_discharge;
	logic irq;
	logic fire;
	logic is_out;
	logic clear;
	logic [3:0] ep;
	logic [6:0] bits;
	int fails;
	int n_tests;
	uem_row_type rows [6];
	logic [31:0] q;
	logic err;
	// =====
	// Clock and instances
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	uem_top uem_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_ev(in_ev), .in_clr(in_clr),
		.out_ev(out_ev), .out_clr(out_clr), .vbus_pulse(vbus_pulse),
		.vbus_discharge(vbus_discharge), .irq(irq));
	uem_ev_source uem_ev_source_i (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire),
		.is_out(is_out), .clear(clear), .ep(ep), .bits(bits), .in_ev(in_ev),
		.in_clr(in_clr), .out_ev(out_ev), .out_clr(out_clr));
	// =====
	// Tasks, all entered just after a rising edge
	task automatic tally_and_finish;
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		// A slave that never answers ends the run
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h1, {31'h0, pready});
			tally_and_finish();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(what, exp, q);
	endtask
	// Event or clear pulse, then time for the pending bit to settle
	task automatic ev(input logic o, input logic c, input logic [3:0] e, input logic [6:0] b);
		fire <= 1'b1;
		is_out <= o;
		clear <= c;
		ep <= e;
		bits <= b;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	// Masked event hidden, revealed on unmask, gone after clear
	task automatic gate_case(input logic o, input int b);
		logic [11:0] ma;
		logic [6:0] one;
		logic [3:0] e;
		int s;
		ma = o ? 12'h814 : 12'h810;
		one = 7'h01 << b;
		e = o ? 4'(15 - b) : 4'(2 * b);
		s = o ? 16 + int'(e) : int'(e);
		wr(ma, {25'h0, ~one});
		ev(o, 1'b0, e, one);
		rd("summary masked", 12'h818, 32'h0);
		wr(ma, {25'h0, one});
		rd("summary unmasked", 12'h818, 32'h1 << s);
		ev(o, 1'b1, e, one);
		rd("summary cleared", 12'h818, 32'h0);
	endtask
	// Cycles a VBUS phase is seen high, counted at each edge
	task automatic span(input string what, input logic d, input int exp);
		int k;
		k = 0;
		while ((d ? vbus_discharge : vbus_pulse) === 1'b1 && k < 5000)
		begin
			k++;
			@(posedge ref_clk);
		end
		chk(what, 32'(exp), 32'(k));
		if (k >= 5000)
			tally_and_finish();
	endtask
	// =====
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		paddr = 12'h0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		fire = 1'b0;
		is_out = 1'b0;
		clear = 1'b0;
		ep = 4'h0;
		bits = 7'h0;
		fails = 0;
		n_tests = 0;
		rows[0] = '{12'h810, 32'hFFFFFFFF, 32'h0000007B, 32'h00000000};
		rows[1] = '{12'h814, 32'hFFFFFFFF, 32'h0000001B, 32'h00000000};
		rows[2] = '{12'h81C, 32'hA5A55A5A, 32'hA5A55A5A, 32'h00000000};
		rows[3] = '{12'h828, 32'hFFFFFFFF, 32'h0000FFFF, 32'h000017D7};
		rows[4] = '{12'h82C, 32'hFFFFFFFF, 32'h00000FFF, 32'h000005B8};
		rows[5] = '{12'h818, 32'hFFFFFFFF, 32'h00000000, 32'h00000000};
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Write then read back the mask, gate, duration and summary registers
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].q);
		end
		// Reset in mid-run restores the mask, gate, duration and summary registers
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (rows[i])
		begin
			rd($sformatf("reset %h", rows[i].a), rows[i].a, rows[i].r);
		end
		apb(12'h800, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		// Every event gate, IN and OUT
		for (int b = 0; b < 7; b++)
		begin
			if (b != 2)
			begin
				gate_case(1'b0, b);
				if (b < 5)
					gate_case(1'b1, b);
			end
		end
		// Interrupt: summary gate, enable, clear
		wr(12'h810, 32'h1);
		wr(12'h848, 32'h1);
		ev(1'b0, 1'b0, 4'h3, 7'h01);
		chk("irq gated", 32'h0, {31'h0, irq});
		wr(12'h81C, 32'h00000008);
		repeat (4) @(posedge ref_clk);
		chk("irq in", 32'h1, {31'h0, irq});
		wr(12'h848, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk("irq disabled", 32'h0, {31'h0, irq});
		ev(1'b0, 1'b1, 4'h3, 7'h01);
		wr(12'h84C, 32'h1);
		wr(12'h848, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(12'h814, 32'h1);
		wr(12'h81C, 32'h00200000);
		ev(1'b1, 1'b0, 4'h5, 7'h01);
		repeat (3) @(posedge ref_clk);
		chk("irq out", 32'h1, {31'h0, irq});
		ev(1'b1, 1'b1, 4'h5, 7'h01);
		wr(12'h84C, 32'h1);
		// Session request: one pulse unit, two discharge units
		wr(12'h82C, 32'h1);
		wr(12'h828, 32'h2);
		wr(12'h840, 32'h1);
		span("pulse cycles", 1'b0, 1024);
		span("discharge cycles", 1'b1, 2048);
		rd("srp status", 12'h844, 32'h2);
		rd("busy", 12'h840, 32'h0);
		// Done interrupt through its own enable, then cleared
		wr(12'h848, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk("irq srp", 32'h1, {31'h0, irq});
		wr(12'h84C, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk("irq srp cleared", 32'h0, {31'h0, irq});
		tally_and_finish();
	end
endmodule
